// ===== design/tso_pkg.sv
// Shared constants, types and arithmetic for the transmit sum-chain output stage
package tso_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NCHAIN = 4;
  localparam int SUM_W = 26;
  localparam int OUT_W = 18;
  localparam int ACC_W = 58;
  localparam int RES_W = 32;
  localparam int HALF_W = 16;
  localparam int CNT_W = 21;
  localparam int CNT_HI_W = 5;
  localparam int DLY_W = 9;
  localparam int SSEL_W = 3;
  localparam int RATE_W = 8;
  localparam int WORD_W = NCHAIN * OUT_W + 1;

  // ----------------------------------------------------------------
  // Field values
  // ----------------------------------------------------------------
  localparam logic [3:0] SCALE_BOTTOM = 4'h8;
  localparam logic [9:0] DELAY_EXTRA = 10'h002;
  localparam logic [27:0] ALL_ONES = 28'hfff_ffff;
  localparam logic signed [27:0] SAT_MAX = 28'sh001_ffff;
  localparam logic signed [27:0] SAT_MIN = 28'shffe_0000;
  localparam logic [2:0] SSEL_TC = 3'h4;
  localparam logic [2:0] SSEL_ONESHOT = 3'h5;
  localparam logic [2:0] SSEL_OFF = 3'h6;
  localparam logic [2:0] SSEL_ON = 3'h7;

  typedef enum logic [1:0] {
    TSO_IDLE = 2'b00,
    TSO_DELAY = 2'b01,
    TSO_RUN = 2'b10
  } tso_meter_st_t;

  // ----------------------------------------------------------------
  // Slice, round and hard-limit one chain value
  // ----------------------------------------------------------------
  function automatic logic [17:0] scale_round(input logic [25:0] x, input logic [3:0] sc,
                                              input logic [1:0] rd);
    logic signed [27:0] v;
    logic [27:0] mask;
    logic [27:0] half;
    logic [3:0] sh;
    sh = (sc > SCALE_BOTTOM) ? 4'h0 : SCALE_BOTTOM - sc;
    v = $signed({{2{x[25]}}, x}) >>> sh;
    mask = ALL_ONES << {rd, 1'b0};
    half = (~mask + 28'h000_0001) >> 1;
    v = v + $signed(half);
    if (v > SAT_MAX) begin
      v = SAT_MAX;
    end else if (v < SAT_MIN) begin
      v = SAT_MIN;
    end
    return v[17:0] & mask[17:0];
  endfunction

  // Pick one sync source; pins arrive already synchronised
  function automatic logic sync_pick(input logic [2:0] sel, input logic [3:0] pins,
                                     input logic tc, input logic oneshot);
    logic r;
    r = 1'b0;
    unique case (sel)
      SSEL_TC: r = tc;
      SSEL_ONESHOT: r = oneshot;
      SSEL_OFF: r = 1'b0;
      SSEL_ON: r = 1'b1;
      default: r = pins[sel[1:0]];
    endcase
    return r;
  endfunction

endpackage

// ===== design/tso_pair_buffer.sv
// Two-entry valid/ready buffer between the formatter and the output pins
`timescale 1ns/1ps
module tso_pair_buffer #(
  parameter int WIDTH = 73,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  logic [DEPTH-1:0][WIDTH-1:0] slot;
  logic [DEPTH-1:0][WIDTH-1:0] next_slot;
  logic [1:0] count;
  logic [1:0] next_count;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // Shift-register storage, head at slot 0
  // ----------------------------------------------------------------
  always_comb begin
    push = in_valid_in && (count != 2'(DEPTH));
    pop = out_ready_in && (count != 2'h0);
    next_slot = slot;
    next_count = count;
    if (pop) begin
      for (int k = 0; k < DEPTH - 1; k++) begin
        next_slot[k] = slot[k+1];
      end
      next_count = count - 2'h1;
    end
    if (push) begin
      next_slot[next_count[0]] = in_data_in;
      next_count = next_count + 2'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      slot <= '0;
      count <= 2'h0;
    end else begin
      slot <= next_slot;
      count <= next_count;
    end
  end

  assign in_ready_out = (count != 2'(DEPTH));
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = slot[0];

endmodule // tso_pair_buffer

// ===== design/tso_power_meter.sv
// Composite RMS power meter for one sum chain
`timescale 1ns/1ps
module tso_power_meter (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Samples
  input wire logic sample_stb_in,
  input wire logic [17:0] sample_i_in,
  input wire logic [17:0] sample_q_in,
  input wire logic sync_in,
  // Settings
  input wire logic [8:0] delay_in,
  input wire logic [20:0] integ_in,
  input wire logic [20:0] interval_in,
  // Result
  output logic [31:0] result_out,
  output logic done_out
);

  tso_pkg::tso_meter_st_t state;
  tso_pkg::tso_meter_st_t next_state;
  logic [9:0] dcnt;
  logic [9:0] next_dcnt;
  logic [20:0] icnt;
  logic [20:0] next_icnt;
  logic [20:0] vcnt;
  logic [20:0] next_vcnt;
  logic [57:0] acc;
  logic [57:0] next_acc;
  logic [31:0] next_result;
  logic next_done;
  logic signed [35:0] sq_i;
  logic signed [35:0] sq_q;
  logic [57:0] pwr;
  logic [9:0] since_sync;

  // ----------------------------------------------------------------
  // Delay, interval and integration sequencing
  // ----------------------------------------------------------------
  always_comb begin
    sq_i = $signed(sample_i_in) * $signed(sample_i_in);
    sq_q = $signed(sample_q_in) * $signed(sample_q_in);
    pwr = 58'($unsigned(sq_i)) + 58'($unsigned(sq_q));
    next_state = state;
    next_dcnt = dcnt;
    next_icnt = icnt;
    next_vcnt = vcnt;
    next_acc = acc;
    next_result = result_out;
    next_done = 1'b0;
    if (sync_in) begin
      next_state = tso_pkg::TSO_DELAY;
      next_dcnt = {1'b0, delay_in} + tso_pkg::DELAY_EXTRA;
    end else begin
      unique case (state)
        tso_pkg::TSO_IDLE: begin
        end
        tso_pkg::TSO_DELAY: begin
          if (sample_stb_in) begin
            next_dcnt = dcnt - 10'h001;
            if (dcnt == 10'h001) begin
              next_state = tso_pkg::TSO_RUN;
              next_icnt = '0;
              next_vcnt = '0;
              next_acc = '0;
            end
          end
        end
        tso_pkg::TSO_RUN: begin
          if (sample_stb_in) begin
            if (icnt < integ_in) begin
              next_acc = acc + pwr;
              next_icnt = icnt + 21'h00_0001;
              if (icnt + 21'h00_0001 == integ_in) begin
                next_result = next_acc[57:26];
                next_done = 1'b1;
              end
            end
            // Interval of value plus one samples; relies on interval above integration
            if (vcnt == interval_in) begin
              next_vcnt = '0;
              next_icnt = '0;
              next_acc = '0;
            end else begin
              next_vcnt = vcnt + 21'h00_0001;
            end
          end
        end
        default: next_state = tso_pkg::TSO_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= tso_pkg::TSO_IDLE;
      dcnt <= '0;
      icnt <= '0;
      vcnt <= '0;
      acc <= '0;
      result_out <= '0;
      done_out <= 1'b0;
    end else begin
      state <= next_state;
      dcnt <= next_dcnt;
      icnt <= next_icnt;
      vcnt <= next_vcnt;
      acc <= next_acc;
      result_out <= next_result;
      done_out <= next_done;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || sync_in) begin
      since_sync <= '0;
    end else if (sample_stb_in && state == tso_pkg::TSO_DELAY) begin
      since_sync <= since_sync + 10'h001;
    end
  end

  default clocking mclk @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  delay_start_a: assert property (
    (state == tso_pkg::TSO_DELAY && next_state == tso_pkg::TSO_RUN && !sync_in)
      |-> (since_sync + 10'h001 == {1'b0, delay_in} + tso_pkg::DELAY_EXTRA))
    else $error("integration started at wrong delay");
  done_count_a: assert property (
    done_out |-> icnt == integ_in)
    else $error("done without full integration count");
  result_top_a: assert property (
    done_out |-> result_out == $past(next_acc[57:26]))
    else $error("result is not accumulator top bits");
  interval_wrap_a: assert property (
    (state == tso_pkg::TSO_RUN && sample_stb_in && !sync_in && vcnt == interval_in)
      |=> (vcnt == 21'h00_0000 && icnt == 21'h00_0000 && acc == 58'h0))
    else $error("interval did not restart");
  acc_add_a: assert property (
    (state == tso_pkg::TSO_RUN && sample_stb_in && !sync_in && icnt < integ_in
      && vcnt != interval_in) |=> acc == $past(acc) + $past(pwr))
    else $error("accumulator missed power sum");
  done_cover_c: cover property (done_out);
  rerun_cover_c: cover property (done_out ##[1:1000] done_out);

endmodule // tso_power_meter

// ===== design/tso_output_stage.sv
// Transmit sum-chain scaling, power metering and output port formatting
`timescale 1ns/1ps

// Function
// - Cut each 26-bit chain to 18-bit slice
// - Scale code 0 takes top, 8 bottom
// - Round, limit, MSB-justify, zero low bits
// - Shared round code keeps 18/16/14/12 bits
// - Four meters, own counters and sync select
// - Sum I and Q squares into accumulator
// - Integrate for programmed sample count
// - Repeat every interval plus one samples
// - First integration after delay plus two
// - Store accumulator top 32 bits, flag done
// - Result readable as two 16-bit halves
// - 21-bit settings split 16 plus 5
// - Disabled port drives data low
// - Drive bits enable port and side pins
// - Real select and interleave select formats
// - I flag high while I sample out, interleaved mode only
// - Split complex maps chains onto port pairs
// - Separate outputs no faster than pin clock
// - Interleaved I/Q alternate each word
// - Test clock period is rate plus one
// - Sample clock output never full rate
// - Chain inputs are 26 bits wide
// - Sync code picks pins, count, one-shot, constants
// - Reading result clears its ready flag
module tso_output_stage (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Sum chain results
  input wire logic [3:0][25:0] chain_i_in,
  input wire logic [3:0][25:0] chain_q_in,
  input wire logic chain_valid_in,
  output logic chain_ready_out,
  // Sync sources
  input wire logic transmit_sync_pin_a_in,
  input wire logic transmit_sync_pin_b_in,
  input wire logic transmit_sync_pin_c_in,
  input wire logic transmit_sync_pin_d_in,
  input wire logic sync_count_tc_in,
  input wire logic sync_oneshot_in,
  // Scaling and format
  input wire logic [3:0][3:0] scale_sel_in,
  input wire logic [1:0] round_sel_in,
  input wire logic [3:0] port_en_in,
  input wire logic [3:0] drive_en_in,
  input wire logic real_sel_in,
  input wire logic interleave_in,
  input wire logic [7:0] test_rate_in,
  // Power meter settings
  input wire logic [3:0][8:0] power_start_delay_in,
  input wire logic [3:0][15:0] power_integrate_len_low_in,
  input wire logic [3:0][4:0] power_integrate_len_high_in,
  input wire logic [3:0][15:0] power_repeat_period_low_in,
  input wire logic [3:0][4:0] power_repeat_period_high_in,
  input wire logic [3:0][2:0] power_sync_sel_in,
  input wire logic [3:0] result_read_in,
  // Power meter results
  output logic [3:0][15:0] chain_power_result_low_out,
  output logic [3:0][15:0] chain_power_result_high_out,
  output logic [3:0] power_done_out,
  output logic [3:0] power_ready_out,
  // Output ports, link clock from the converter side
  input wire logic dac_clk_in,
  output logic [17:0] output_port_zero_out,
  output logic [17:0] output_port_one_out,
  output logic [17:0] output_port_two_out,
  output logic [17:0] output_port_three_out,
  output logic [3:0] output_port_oe_n_out,
  output logic iflag_out,
  output logic sample_clk_out,
  output logic iflag_clk_oe_n_out,
  output logic test_clk_out,
  output logic test_sync_out,
  output logic test_flag_out,
  output logic test_pins_oe_n_out
);

  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic lk_s1;
  logic lk_s2;
  logic lk_prev;
  logic lk_edge;
  logic [3:0] sync_lvl;
  logic [3:0] sync_prev;
  logic [3:0] sync_edge;
  logic [3:0][17:0] sc_i;
  logic [3:0][17:0] sc_q;
  logic [3:0][17:0] next_sc_i;
  logic [3:0][17:0] next_sc_q;
  logic sc_valid;
  logic next_sc_valid;
  logic phase;
  logic next_phase;
  logic meter_stb;
  logic next_meter_stb;
  logic accept;
  logic push;
  logic last;
  logic interl_mode;
  logic [tso_pkg::WORD_W-1:0] word;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [tso_pkg::WORD_W-1:0] buf_out_data;
  logic drain;
  logic [3:0][17:0] port;
  logic [3:0][17:0] next_port;
  logic next_iflag;
  logic next_sample_clk;
  logic [7:0] tcnt;
  logic [7:0] next_tcnt;
  logic next_test_clk;
  logic [3:0][31:0] result;
  logic [3:0] done;
  logic [3:0] next_ready;

  // ----------------------------------------------------------------
  // Pin synchronisers and link clock edge
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      lk_s1 <= 1'b0;
      lk_s2 <= 1'b0;
      lk_prev <= 1'b0;
      sync_prev <= 4'h0;
    end else begin
      pin_s1 <= {transmit_sync_pin_d_in, transmit_sync_pin_c_in,
                 transmit_sync_pin_b_in, transmit_sync_pin_a_in};
      pin_s2 <= pin_s1;
      lk_s1 <= dac_clk_in;
      lk_s2 <= lk_s1;
      lk_prev <= lk_s2;
      sync_prev <= sync_lvl;
    end
  end

  always_comb begin
    lk_edge = lk_s2 && !lk_prev;
    for (int k = 0; k < tso_pkg::NCHAIN; k++) begin
      sync_lvl[k] = tso_pkg::sync_pick(power_sync_sel_in[k], pin_s2,
                                       sync_count_tc_in, sync_oneshot_in);
    end
    sync_edge = sync_lvl & ~sync_prev;
  end

  // ----------------------------------------------------------------
  // Scale, round and format into buffer words
  // ----------------------------------------------------------------
  always_comb begin
    // One sample every other cycle at most, keeping within half clock rate
    accept = chain_valid_in && chain_ready_out;
    interl_mode = interleave_in && !real_sel_in;
    last = !interl_mode || phase;
    push = sc_valid;
    for (int k = 0; k < tso_pkg::NCHAIN; k++) begin
      word[k*18 +: 18] = interl_mode && phase ? sc_q[k] : sc_i[k];
    end
    if (!real_sel_in && !interleave_in) begin
      word[71:0] = {sc_q[1], sc_i[1], sc_q[0], sc_i[0]};
    end
    word[72] = interl_mode && !phase;
    next_sc_i = sc_i;
    next_sc_q = sc_q;
    next_sc_valid = sc_valid;
    next_phase = phase;
    next_meter_stb = 1'b0;
    if (push && buf_in_ready) begin
      next_phase = !last;
      next_sc_valid = !last;
    end
    if (accept) begin
      for (int k = 0; k < tso_pkg::NCHAIN; k++) begin
        next_sc_i[k] = tso_pkg::scale_round(chain_i_in[k], scale_sel_in[k],
                                            round_sel_in);
        next_sc_q[k] = tso_pkg::scale_round(chain_q_in[k], scale_sel_in[k], round_sel_in);
      end
      next_sc_valid = 1'b1;
      next_phase = 1'b0;
      next_meter_stb = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sc_i <= '0;
      sc_q <= '0;
      sc_valid <= 1'b0;
      phase <= 1'b0;
      meter_stb <= 1'b0;
      chain_ready_out <= 1'b0;
    end else begin
      sc_i <= next_sc_i;
      sc_q <= next_sc_q;
      sc_valid <= next_sc_valid;
      phase <= next_phase;
      meter_stb <= next_meter_stb;
      chain_ready_out <= !next_sc_valid;
    end
  end

  // Stall from the converter side backs up to chain_ready_out
  tso_pair_buffer #(
    .WIDTH(tso_pkg::WORD_W),
    .DEPTH(2)
  ) u_buf (
    .clk_in(core_clk_in),
    .rst_in(sys_rst_in),
    .in_valid_in(push),
    .in_ready_out(buf_in_ready),
    .in_data_in(word),
    .out_valid_out(buf_out_valid),
    .out_ready_in(lk_edge),
    .out_data_out(buf_out_data)
  );

  // ----------------------------------------------------------------
  // Output ports and clocks
  // ----------------------------------------------------------------
  always_comb begin
    drain = lk_edge && buf_out_valid;
    next_port = port;
    next_iflag = iflag_out;
    next_sample_clk = sample_clk_out;
    if (drain) begin
      for (int k = 0; k < tso_pkg::NCHAIN; k++) begin
        next_port[k] = port_en_in[k] ? buf_out_data[k*18 +: 18] : 18'h0_0000;
      end
      next_iflag = buf_out_data[72];
      // Toggles per word, so it runs at half the word rate at most
      next_sample_clk = !sample_clk_out;
    end
    next_tcnt = (tcnt >= test_rate_in) ? 8'h00 : tcnt + 8'h01;
    next_test_clk = (next_tcnt <= (test_rate_in >> 1));
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      port <= '0;
      iflag_out <= 1'b0;
      sample_clk_out <= 1'b0;
      tcnt <= 8'h00;
      test_clk_out <= 1'b0;
      test_sync_out <= 1'b0;
      test_flag_out <= 1'b0;
      output_port_oe_n_out <= 4'hf;
      iflag_clk_oe_n_out <= 1'b1;
      test_pins_oe_n_out <= 1'b1;
      power_ready_out <= 4'h0;
    end else begin
      port <= next_port;
      iflag_out <= next_iflag;
      sample_clk_out <= next_sample_clk;
      tcnt <= next_tcnt;
      test_clk_out <= next_test_clk;
      test_sync_out <= |sync_edge;
      test_flag_out <= |done;
      output_port_oe_n_out <= ~drive_en_in;
      iflag_clk_oe_n_out <= !drive_en_in[0];
      test_pins_oe_n_out <= !drive_en_in[2];
      power_ready_out <= next_ready;
    end
  end

  // Ready flag: a new result in the same cycle as a read stays flagged
  always_comb begin
    next_ready = (power_ready_out & ~result_read_in) | done;
  end

  assign output_port_zero_out = port[0];
  assign output_port_one_out = port[1];
  assign output_port_two_out = port[2];
  assign output_port_three_out = port[3];

  // ----------------------------------------------------------------
  // Power meters
  // ----------------------------------------------------------------
  for (genvar g = 0; g < tso_pkg::NCHAIN; g++) begin : g_meter
    tso_power_meter u_meter (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .sample_stb_in(meter_stb),
      .sample_i_in(sc_i[g]),
      .sample_q_in(sc_q[g]),
      .sync_in(sync_edge[g]),
      .delay_in(power_start_delay_in[g]),
      .integ_in({power_integrate_len_high_in[g], power_integrate_len_low_in[g]}),
      .interval_in({power_repeat_period_high_in[g], power_repeat_period_low_in[g]}),
      .result_out(result[g]),
      .done_out(done[g])
    );
    assign chain_power_result_low_out[g] = result[g][15:0];
    assign chain_power_result_high_out[g] = result[g][31:16];
  end
  assign power_done_out = done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking tclk @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  port_disable_a: assert property (
    (drain && !port_en_in[3]) |=> output_port_three_out == 18'h0_0000)
    else $error("disabled port not held low");
  drive_pins_a: assert property (
    ##1 (output_port_oe_n_out[2] == !$past(drive_en_in[2])
      && test_pins_oe_n_out == output_port_oe_n_out[2]
      && iflag_clk_oe_n_out == output_port_oe_n_out[0]))
    else $error("drive enable mismatch");
  iflag_first_a: assert property (
    (push && buf_in_ready && interl_mode && !phase) |-> word[72] ##1 push && phase)
    else $error("interleave did not start with I");
  round_zero_a: assert property (
    (meter_stb && $past(round_sel_in) == 2'b11) |-> sc_i[0][5:0] == 6'h00)
    else $error("low bits not zeroed");
  split_map_a: assert property (
    (drain && !real_sel_in && !interleave_in && port_en_in[1])
      |=> output_port_one_out == $past(buf_out_data[35:18]))
    else $error("split complex mapping wrong");
  test_clk_wrap_a: assert property (
    (tcnt == test_rate_in && $stable(test_rate_in)) |=> tcnt == 8'h00)
    else $error("test clock period wrong");
  ready_set_a: assert property (
    done[1] |=> power_ready_out[1])
    else $error("ready flag lost");
  stall_cover_c: cover property (chain_valid_in && !chain_ready_out && !buf_in_ready);
  interl_cover_c: cover property (drain && interl_mode && buf_out_data[72]);
  read_cover_c: cover property (power_ready_out[0] && result_read_in[0]);

endmodule // tso_output_stage

// ===== dv/tso_dac_model.sv
// Converter-side model: link clock source and word capture
`timescale 1ns/1ps
module tso_dac_model (
  // Control
  input wire logic run_in,
  // Link
  input wire logic [17:0] port_in,
  output logic dac_clk_out,
  output logic [17:0] cap_out
);
  // Clock stands low outside a run, so no stray pops
  initial dac_clk_out = 1'b0;
  always #400 dac_clk_out = run_in ? ~dac_clk_out : 1'b0;
  always @(posedge dac_clk_out) cap_out <= port_in;
endmodule // tso_dac_model

// ===== dv/testbench.sv
// Self-checking bench for the sum-chain output stage
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, v = 1'b0, rl = 1'b1, il = 1'b0, pa = 1'b0, dclk;
  logic [3:0][25:0] ci = '0, cq = '0;
  logic [3:0][3:0] sc = '0;
  logic [1:0] rd = '0;
  logic [3:0] pen = '0, den = '0, rr = '0, oen, prdy;
  logic [7:0] tr = '0;
  logic [3:0][8:0] dly = '0;
  logic [3:0][15:0] ilo = '0, rpl = '0, plo, phi;
  logic [3:0][4:0] ihi = '0, rph = '0;
  logic [3:0][2:0] ssel = {4{3'h6}};
  logic [3:0][17:0] pt;
  logic [17:0] cap;
  logic rdy, ifl, sclk, ioe, toe, tc = 1'b0;
  logic [15:0] seed = 16'h0014, r;
  int err_count = 0, checks_done = 0, n;
  always #50 clk = ~clk;
  tso_dac_model tso_dac_model_inst (.run_in(1'b1), .port_in(pt[0]), .dac_clk_out(dclk),
    .cap_out(cap));
  tso_output_stage tso_output_stage_inst (.core_clk_in(clk), .sys_rst_in(rst),
    .chain_i_in(ci), .chain_q_in(cq), .chain_valid_in(v), .chain_ready_out(rdy),
    .transmit_sync_pin_a_in(pa), .transmit_sync_pin_b_in(1'b0),
    .transmit_sync_pin_c_in(1'b0), .transmit_sync_pin_d_in(1'b0), .sync_count_tc_in(tc),
    .sync_oneshot_in(1'b0), .scale_sel_in(sc), .round_sel_in(rd), .port_en_in(pen),
    .drive_en_in(den), .real_sel_in(rl), .interleave_in(il), .test_rate_in(tr),
    .power_start_delay_in(dly), .power_integrate_len_low_in(ilo),
    .power_integrate_len_high_in(ihi), .power_repeat_period_low_in(rpl),
    .power_repeat_period_high_in(rph), .power_sync_sel_in(ssel), .result_read_in(rr),
    .chain_power_result_low_out(plo), .chain_power_result_high_out(phi),
    .power_done_out(), .power_ready_out(prdy), .dac_clk_in(dclk),
    .output_port_zero_out(pt[0]), .output_port_one_out(pt[1]),
    .output_port_two_out(pt[2]), .output_port_three_out(pt[3]),
    .output_port_oe_n_out(oen), .iflag_out(ifl), .sample_clk_out(sclk),
    .iflag_clk_oe_n_out(ioe), .test_clk_out(), .test_sync_out(), .test_flag_out(),
    .test_pins_oe_n_out(toe));
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  // Slice, round half up, then clamp to the 18-bit signed range
  function automatic logic [17:0] exp_w(logic [25:0] x, logic [3:0] s, logic [1:0] q);
    logic signed [27:0] t;
    t = $signed({{2{x[25]}}, x}) >>> (4'h8 - s);
    if (q != 2'h0) t = t + (28'sh000_0001 <<< (2 * q - 1));
    if (t > 28'sh001_ffff) t = 28'sh001_ffff;
    if (t < 28'shffe_0000) t = 28'shffe_0000;
    return t[17:0] & (18'h3_ffff << (2 * q));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic guard(input int k);
    if (k >= 80) begin
      err_count++;
      close_out();
    end
  endtask
  task automatic send();
    int k;
    step();
    v = 1'b1;
    for (k = 0; k < 80 && rdy !== 1'b1; k++) step();
    guard(k);
    step();
    v = 1'b0;
  endtask
  task automatic wait_word();
    logic s;
    int k;
    s = sclk;
    for (k = 0; k < 80 && sclk === s; k++) step();
    guard(k);
  endtask
  initial begin
    repeat (2) step();
    chk(32'(oen), 32'h0000_000f);
    rst = 1'b0;
    // Real mode; first two passes hit full-scale corners at codes 0 and 8
    for (int k = 0; k < 10; k++) begin
      r = rnd();
      {tr, den, pen} = r;
      pa = r[0];
      rd = 2'(3 - k);
      for (int c = 0; c < 4; c++) begin
        r = rnd();
        sc[c] = (k < 2) ? {k[0], 3'h0} : 4'(r % 9);
        ci[c] = (k == 0) ? 26'h1ff_ffff : (k == 1) ? 26'h200_0000 : {r[9:0], rnd()};
      end
      send();
      wait_word();
      chk(32'(oen), 32'(den ^ 4'hf));
      chk(32'(ioe), 32'(!den[0]));
      chk(32'(toe), 32'(!den[2]));
      for (int c = 0; c < 4; c++)
        chk(32'(pt[c]), 32'(pen[c] ? exp_w(ci[c], sc[c], rd) : 18'h0));
      // Next converter edge must capture the same word
      repeat (8) step();
      chk(32'(cap), 32'(pen[0] ? exp_w(ci[0], sc[0], rd) : 18'h0));
      $display("real pass %0d done", k);
    end
    {rl, pen, rd, sc} = {1'b0, 4'hf, 2'h0, {4{4'h8}}};
    for (int k = 0; k < 6; k++) begin
      il = (k > 2);
      for (int c = 0; c < 2; c++) begin
        ci[c] = 26'({rnd(), rnd()});
        cq[c] = 26'({rnd(), rnd()});
      end
      send();
      wait_word();
      if (il) begin
        chk(32'({ifl, pt[0]}), 32'({1'b1, exp_w(ci[0], 4'h8, 2'h0)}));
        wait_word();
        chk(32'({ifl, pt[0]}), 32'({1'b0, exp_w(cq[0], 4'h8, 2'h0)}));
      end else begin
        for (int c = 0; c < 2; c++) begin
          chk(32'(pt[2*c]), 32'(exp_w(ci[c], 4'h8, 2'h0)));
          chk(32'(pt[2*c+1]), 32'(exp_w(cq[c], 4'h8, 2'h0)));
        end
      end
      $display("complex pass %0d done", k);
    end
    // Meter 0: two full-scale samples integrated, interval of four samples
    {il, ilo[0], rpl[0]} = {1'b0, 16'h0002, 16'h0003};
    ci[0] = 26'h001_ffff;
    cq[0] = 26'h001_ffff;
    ssel[0] = 3'h7;
    for (n = 0; n < 20 && prdy[0] !== 1'b1; n++) send();
    if (n == 20) guard(80);
    chk({phi[0], plo[0]}, 32'((64'd131071 * 64'd131071 * 64'd4) >> 26));
    rr[0] = 1'b1;
    step();
    rr[0] = 1'b0;
    step();
    chk(32'(prdy[0]), 32'h0);
    // Restart from the count source; free running would finish one sample sooner
    ssel[0] = 3'h4;
    step();
    tc = 1'b1;
    step();
    tc = 1'b0;
    for (n = 0; n < 20 && prdy[0] !== 1'b1; n++) send();
    chk(32'(n), 32'h0000_0005);
    $display("meter pass done");
    close_out();
  end
endmodule // testbench
